// ==== include/bit_ops_pkg.sv ====
`default_nettype none
// ****************************************************************
// Operation codes, flag positions and reset values.
// ****************************************************************
package bit_ops_pkg;

    // Operation select for the bit and flag group.
    typedef enum logic [3:0]
    {
        OP_NONE,
        OP_IO_BIT_CLEAR,
        OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_SHIFT_RIGHT_SIGNED,
        OP_NIBBLE_EXCHANGE,
        OP_FLAG_SET,
        OP_FLAG_CLEAR,
        OP_COPY_BIT_TO_HOLD,
        OP_LOAD_BIT_FROM_HOLD,
        OP_CARRY_SET,
        OP_CARRY_CLEAR
    } op_t;

    // Bit positions inside the flags word.
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    // Reset values of the result and flag registers.
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET  = 8'h00;

endpackage : bit_ops_pkg
`default_nettype wire

// ==== design/bit_shift_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Combinational shifter: computes the new operand and flags.
// ****************************************************************
module bit_shift_core
(
    input  wire logic [3:0] opCode,
    input  wire logic [7:0] operand,
    input  wire logic [2:0] bitSel,
    input  wire logic [7:0] flagsIn,
    output var  logic [7:0] resultOut,
    output var  logic       writeResult,
    output var  logic [7:0] flagsOut
);

    bit_ops_pkg::op_t op;
    logic             carryIn;
    logic             newC;
    logic             newN;

    assign op      = bit_ops_pkg::op_t'(opCode);
    assign carryIn = flagsIn[bit_ops_pkg::FLAG_C];

    // Compute result, then the arithmetic flags for shift and rotate forms.
    always_comb
    begin
        resultOut   = operand;
        writeResult = 1'b0;
        flagsOut    = flagsIn;
        newC        = carryIn;
        unique case (op)
            bit_ops_pkg::OP_IO_BIT_CLEAR:
            begin
                resultOut[bitSel] = 1'b0;
                writeResult       = 1'b1;
            end
            bit_ops_pkg::OP_SHIFT_LEFT_LOGICAL:
            begin
                resultOut   = {operand[6:0], 1'b0};
                newC        = operand[7];
                writeResult = 1'b1;
            end
            bit_ops_pkg::OP_SHIFT_RIGHT_LOGICAL:
            begin
                resultOut   = {1'b0, operand[7:1]};
                newC        = operand[0];
                writeResult = 1'b1;
            end
            bit_ops_pkg::OP_ROTATE_LEFT_CARRY:
            begin
                resultOut   = {operand[6:0], carryIn};
                newC        = operand[7];
                writeResult = 1'b1;
            end
            bit_ops_pkg::OP_ROTATE_RIGHT_CARRY:
            begin
                resultOut   = {carryIn, operand[7:1]};
                newC        = operand[0];
                writeResult = 1'b1;
            end
            bit_ops_pkg::OP_SHIFT_RIGHT_SIGNED:
            begin
                resultOut   = {operand[7], operand[7:1]};
                newC        = operand[0];
                writeResult = 1'b1;
            end
            bit_ops_pkg::OP_NIBBLE_EXCHANGE:
            begin
                resultOut   = {operand[3:0], operand[7:4]};
                writeResult = 1'b1;
            end
            bit_ops_pkg::OP_FLAG_SET:
            begin
                flagsOut[bitSel] = 1'b1;
            end
            bit_ops_pkg::OP_FLAG_CLEAR:
            begin
                flagsOut[bitSel] = 1'b0;
            end
            bit_ops_pkg::OP_COPY_BIT_TO_HOLD:
            begin
                flagsOut[bit_ops_pkg::FLAG_T] = operand[bitSel];
            end
            bit_ops_pkg::OP_LOAD_BIT_FROM_HOLD:
            begin
                resultOut[bitSel] = flagsIn[bit_ops_pkg::FLAG_T];
                writeResult       = 1'b1;
            end
            bit_ops_pkg::OP_CARRY_SET:
            begin
                flagsOut[bit_ops_pkg::FLAG_C] = 1'b1;
            end
            bit_ops_pkg::OP_CARRY_CLEAR:
            begin
                flagsOut[bit_ops_pkg::FLAG_C] = 1'b0;
            end
            default:
            begin
                resultOut = operand;
            end
        endcase
        // Overflow follows the usual N xor C relation for every shift form.
        newN = resultOut[7];
        if (op inside {bit_ops_pkg::OP_SHIFT_LEFT_LOGICAL, bit_ops_pkg::OP_SHIFT_RIGHT_LOGICAL,
                       bit_ops_pkg::OP_ROTATE_LEFT_CARRY, bit_ops_pkg::OP_ROTATE_RIGHT_CARRY,
                       bit_ops_pkg::OP_SHIFT_RIGHT_SIGNED})
        begin
            flagsOut[bit_ops_pkg::FLAG_Z] = (resultOut == 8'h00);
            flagsOut[bit_ops_pkg::FLAG_C] = newC;
            flagsOut[bit_ops_pkg::FLAG_N] = newN;
            flagsOut[bit_ops_pkg::FLAG_V] = newN ^ newC;
        end
    end

endmodule : bit_shift_core
`default_nettype wire

// ==== design/bit_shift_flag_ops.sv ====
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_ops
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       opValid,
    input  wire logic [3:0] opCode,
    input  wire logic [7:0] operandIn,
    input  wire logic [2:0] bitSel,
    output var  logic [7:0] result_q,
    output var  logic       resultWrite_q,
    output var  logic       done_q,
    output var  logic [7:0] flags_q
);

    logic [7:0] coreResult;
    logic       coreWrite;
    logic [7:0] coreFlags;
    logic [7:0] result_d;
    logic       resultWrite_d;
    logic       done_d;
    logic [7:0] flags_d;

    // ****************************************************************
    // Datapath
    // ****************************************************************

    // The flags word lives here so back-to-back operations see fresh flags.
    bit_shift_core u_core
    (
        .opCode      (opCode),
        .operand     (operandIn),
        .bitSel      (bitSel),
        .flagsIn     (flags_q),
        .resultOut   (coreResult),
        .writeResult (coreWrite),
        .flagsOut    (coreFlags)
    );

    // Next state: an idle cycle holds the flags and result unchanged.
    always_comb
    begin
        result_d      = result_q;
        resultWrite_d = 1'b0;
        done_d        = opValid;
        flags_d       = flags_q;
        if (opValid)
        begin
            flags_d       = coreFlags;
            resultWrite_d = coreWrite;
            if (coreWrite)
            begin
                result_d = coreResult;
            end
        end
    end

    // Register stage; one cycle from request to answer.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result_q      <= bit_ops_pkg::RESULT_RESET;
            resultWrite_q <= 1'b0;
            done_q        <= 1'b0;
            flags_q       <= bit_ops_pkg::FLAGS_RESET;
        end
        else
        begin
            result_q      <= result_d;
            resultWrite_q <= resultWrite_d;
            done_q        <= done_d;
            flags_q       <= flags_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    // One clock domain, so every check below shares the clock and the reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Clearing an I/O bit touches only the addressed bit.
    chk_io_clear_bit: assert property (
        opValid && opCode == bit_ops_pkg::OP_IO_BIT_CLEAR
        |=> result_q == ($past(operandIn) & ~(8'h01 << $past(bitSel))))
        else $error("io bit clear wrong");

    // Logical shift left brings a zero in at the bottom and the old top bit out into carry.
    chk_shl_value: assert property (
        opValid && opCode == bit_ops_pkg::OP_SHIFT_LEFT_LOGICAL
        |=> result_q == {$past(operandIn[6:0]), 1'b0} && flags_q[bit_ops_pkg::FLAG_C] == $past(operandIn[7]))
        else $error("shift left wrong");

    // The other three shift flags follow from the stored result and carry.
    chk_shl_flags: assert property (
        opValid && opCode == bit_ops_pkg::OP_SHIFT_LEFT_LOGICAL
        |=> flags_q[bit_ops_pkg::FLAG_Z] == (result_q == 8'h00) && flags_q[bit_ops_pkg::FLAG_N] == result_q[7]
            && flags_q[bit_ops_pkg::FLAG_V] == (result_q[7] ^ flags_q[bit_ops_pkg::FLAG_C]))
        else $error("shift left flags wrong");

    // Logical shift right brings a zero in at the top; the old bottom bit goes to carry.
    chk_shr_value: assert property (
        opValid && opCode == bit_ops_pkg::OP_SHIFT_RIGHT_LOGICAL
        |=> result_q == {1'b0, $past(operandIn[7:1])} && flags_q[bit_ops_pkg::FLAG_Z] == (result_q == 8'h00)
            && flags_q[bit_ops_pkg::FLAG_C] == $past(operandIn[0]))
        else $error("shift right wrong");

    // Rotate left feeds the old carry in at the bottom and the old top bit out.
    chk_rotate_left: assert property (
        opValid && opCode == bit_ops_pkg::OP_ROTATE_LEFT_CARRY
        |=> result_q == {$past(operandIn[6:0]), $past(flags_q[bit_ops_pkg::FLAG_C])}
            && flags_q[bit_ops_pkg::FLAG_C] == $past(operandIn[7]))
        else $error("rotate left wrong");

    // Rotate right feeds the old carry in at the top; overflow stays N xor C.
    chk_rotate_right: assert property (
        opValid && opCode == bit_ops_pkg::OP_ROTATE_RIGHT_CARRY
        |=> result_q == {$past(flags_q[bit_ops_pkg::FLAG_C]), $past(operandIn[7:1])}
            && flags_q[bit_ops_pkg::FLAG_V] == (flags_q[bit_ops_pkg::FLAG_N] ^ flags_q[bit_ops_pkg::FLAG_C])
            && flags_q[bit_ops_pkg::FLAG_C] == $past(operandIn[0]))
        else $error("rotate right wrong");

    // Signed shift right keeps the sign bit in place.
    chk_signed_shift: assert property (
        opValid && opCode == bit_ops_pkg::OP_SHIFT_RIGHT_SIGNED
        |=> result_q[7] == $past(operandIn[7]) && result_q[6:0] == $past(operandIn[7:1]))
        else $error("signed shift wrong");

    // The bit shifted out of a signed shift lands in carry, and Z follows the result.
    chk_signed_flags: assert property (
        opValid && opCode == bit_ops_pkg::OP_SHIFT_RIGHT_SIGNED
        |=> flags_q[bit_ops_pkg::FLAG_C] == $past(operandIn[0])
            && flags_q[bit_ops_pkg::FLAG_Z] == (result_q == 8'h00))
        else $error("signed shift flags wrong");

    // Nibble exchange swaps the halves and must leave every flag alone.
    chk_swap_flags: assert property (
        opValid && opCode == bit_ops_pkg::OP_NIBBLE_EXCHANGE
        |=> flags_q == $past(flags_q) && result_q == {$past(operandIn[3:0]), $past(operandIn[7:4])})
        else $error("nibble swap wrong");

    // Flag set raises exactly the selected flag.
    chk_flag_set: assert property (
        opValid && opCode == bit_ops_pkg::OP_FLAG_SET
        |=> flags_q == ($past(flags_q) | (8'h01 << $past(bitSel))))
        else $error("flag set wrong");

    // Flag clear lowers exactly the selected flag.
    chk_flag_clear: assert property (
        opValid && opCode == bit_ops_pkg::OP_FLAG_CLEAR
        |=> flags_q == ($past(flags_q) & ~(8'h01 << $past(bitSel))))
        else $error("flag clear wrong");

    // Copy to hold changes T alone; every other flag keeps its value.
    chk_hold_copy: assert property (
        opValid && opCode == bit_ops_pkg::OP_COPY_BIT_TO_HOLD
        |=> flags_q[bit_ops_pkg::FLAG_T] == $past(operandIn[bitSel])
            && (flags_q & ~(8'h01 << bit_ops_pkg::FLAG_T)) == ($past(flags_q) & ~(8'h01 << bit_ops_pkg::FLAG_T)))
        else $error("copy to hold wrong");

    // Load from hold writes T into bit b and leaves the flags alone.
    chk_hold_load: assert property (
        opValid && opCode == bit_ops_pkg::OP_LOAD_BIT_FROM_HOLD
        |=> result_q[$past(bitSel)] == $past(flags_q[bit_ops_pkg::FLAG_T]) && flags_q == $past(flags_q))
        else $error("load from hold wrong");

    // Carry set raises carry and nothing else.
    chk_carry_only: assert property (
        opValid && opCode == bit_ops_pkg::OP_CARRY_SET
        |=> flags_q == ($past(flags_q) | (8'h01 << bit_ops_pkg::FLAG_C)))
        else $error("carry set wrong");

    // Carry clear lowers carry and nothing else.
    chk_carry_clear: assert property (
        opValid && opCode == bit_ops_pkg::OP_CARRY_CLEAR
        |=> flags_q == ($past(flags_q) & ~(8'h01 << bit_ops_pkg::FLAG_C)))
        else $error("carry clear wrong");

    // Every accepted request is answered on the very next edge.
    chk_done_timing: assert property (
        opValid |=> done_q ##1 (done_q == $past(opValid)))
        else $error("done timing wrong");

    // A cycle without a request must leave every output quiet and every stored value held.
    chk_idle_quiet: assert property (
        !opValid
        |=> !done_q && !resultWrite_q && $stable(result_q) && $stable(flags_q))
        else $error("idle cycle not quiet");

    // Unknown codes only pulse done; a stray code must never corrupt a register or a flag.
    chk_refused_code: assert property (
        opValid && (opCode == bit_ops_pkg::OP_NONE || opCode > bit_ops_pkg::OP_CARRY_CLEAR)
        |=> done_q && !resultWrite_q && $stable(result_q) && $stable(flags_q))
        else $error("refused code changed state");

    // ****************************************************************
    // Coverage
    // ****************************************************************

    // Main scenarios: a plain shift, a rotate pair, a hold round trip, a stray code and a flag clear.
    cov_shift_left: cover property (
        opValid && opCode == bit_ops_pkg::OP_SHIFT_LEFT_LOGICAL);
    cov_rotate_chain: cover property (
        opValid && opCode == bit_ops_pkg::OP_ROTATE_LEFT_CARRY
        ##1 opValid && opCode == bit_ops_pkg::OP_ROTATE_RIGHT_CARRY);
    cov_hold_round: cover property (
        opValid && opCode == bit_ops_pkg::OP_COPY_BIT_TO_HOLD
        ##1 opValid && opCode == bit_ops_pkg::OP_LOAD_BIT_FROM_HOLD);
    cov_refused_code: cover property (
        opValid && opCode > bit_ops_pkg::OP_CARRY_CLEAR);
    cov_flag_clear: cover property (
        opValid && opCode == bit_ops_pkg::OP_FLAG_CLEAR ##1 done_q);

endmodule : bit_shift_flag_ops
`default_nettype wire

// ==== verification/reg_file_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Register file on the far side of the bit and flag datapath.
// ****************************************************************
module reg_file_model
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [1:0] sel,
    input  wire logic       loadEn,
    input  wire logic [7:0] loadVal,
    input  wire logic [7:0] resultIn,
    input  wire logic       resultWrite,
    output var  logic [7:0] operand
);
    logic [7:0] regs_q [4];
    logic [1:0] selHeld_q;

    // Write-back wins over a load, so a returned result is never lost.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regs_q    <= '{8'h81, 8'h00, 8'h7F, 8'hC3};
            selHeld_q <= 2'h0;
        end
        else
        begin
            selHeld_q <= sel;
            if (resultWrite)
                regs_q[selHeld_q] <= resultIn;
            else if (loadEn)
                regs_q[sel] <= loadVal;
        end
    end

    // The selected register is offered to the datapath without delay.
    assign operand = regs_q[sel];
endmodule : reg_file_model
`default_nettype wire

// ==== verification/bit_shift_flag_ops_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_ops_bench;
    logic       clk, resetn, opValid, loadEn, resultWrite_q, done_q, expW, expD;
    logic [3:0] opCode;
    logic [2:0] bitSel;
    logic [1:0] sel;
    logic [7:0] loadVal, operand, result_q, flags_q, expR, expF, o;
    logic [8:0] s;
    logic [31:0] rnd;
    int         seed, failCount, nChecks;

    // The datapath under test and the register file that feeds it and takes its results back.
    bit_shift_flag_ops u_bit_shift_flag_ops (.clk(clk), .resetn(resetn), .opValid(opValid), .opCode(opCode),
        .operandIn(operand), .bitSel(bitSel), .result_q(result_q), .resultWrite_q(resultWrite_q),
        .done_q(done_q), .flags_q(flags_q));
    reg_file_model u_reg_file_model (.clk(clk), .resetn(resetn), .sel(sel), .loadEn(loadEn), .loadVal(loadVal),
        .resultIn(result_q), .resultWrite(resultWrite_q), .operand(operand));

    // Free-running 100 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Every comparison passes through here, so a mismatch is counted and printed in one form.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // The single place where the run ends, from the traffic loop and the watchdog alike.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    // One random request per falling edge; the model predicts what the next edge must show.
    task automatic step;
        rnd     = $random(seed);
        opValid = rnd[1:0] != 2'h0;
        opCode  = rnd[5:2];
        bitSel  = rnd[8:6];
        sel     = rnd[10:9];
        loadEn  = rnd[13:11] == 3'h0;
        loadVal = rnd[21:14];
        #1;
        expW = 1'b0;
        expD = opValid;
        if (opValid)
        begin
            o = operand;
            s = {expF[0], 8'h00};
            case (opCode)
                4'h1: s[7:0] = o & ~(8'h01 << bitSel);
                4'h2: s = {o, 1'b0};
                4'h3: s = {o[0], 1'b0, o[7:1]};
                4'h4: s = {o, expF[0]};
                4'h5: s = {o[0], expF[0], o[7:1]};
                4'h6: s = {o[0], o[7], o[7:1]};
                4'h7: s[7:0] = {o[3:0], o[7:4]};
                4'h8: expF[bitSel] = 1'b1;
                4'h9: expF[bitSel] = 1'b0;
                4'hA: expF[6] = o[bitSel];
                4'hB: s[7:0] = (o & ~(8'h01 << bitSel)) | ({7'h00, expF[6]} << bitSel);
                4'hC: expF[0] = 1'b1;
                4'hD: expF[0] = 1'b0;
                default: ;
            endcase
            // Shifts and rotates share one flag rule: V is N xor C.
            if (opCode >= 4'h2 && opCode <= 4'h6)
                expF[3:0] = {s[7] ^ s[8], s[7], s[7:0] == 8'h00, s[8]};
            expW = (opCode >= 4'h1 && opCode <= 4'h7) || opCode == 4'hB;
            if (expW)
                expR = s[7:0];
        end
    endtask : step

    // Reset, then back-to-back random traffic checked at every cycle, with one more reset in mid-run.
    initial
    begin
        seed = 27275;
        {failCount, nChecks} = '0;
        {resetn, opValid, loadEn, expW, expD} = '0;
        {opCode, bitSel, sel, loadVal, expR, expF} = '0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 3000; i++)
        begin
            @(negedge clk);
            check("result", result_q, expR);
            check("flags", flags_q, expF);
            check("write", {7'h00, resultWrite_q}, {7'h00, expW});
            check("done", {7'h00, done_q}, {7'h00, expD});
            // A reset after busy traffic must clear stored result and flags at once, not only at start-up.
            if (i == 1500)
            begin
                {resetn, opValid, loadEn} = '0;
                {expR, expF, expW, expD} = '0;
                @(negedge clk);
                check("reset result", result_q, expR);
                check("reset flags", flags_q, expF);
                check("reset write", {7'h00, resultWrite_q}, {7'h00, expW});
                check("reset done", {7'h00, done_q}, {7'h00, expD});
                resetn = 1'b1;
            end
            step();
        end
        finish_test();
    end

    // A hang is cut off well after the 3000 cycles of traffic.
    initial
    begin
        #100000;
        failCount++;
        finish_test();
    end
endmodule : bit_shift_flag_ops_bench
`default_nettype wire
